// ==== rtl/orr_pkg.sv ====
`default_nettype none
package orr_pkg;
    localparam int NUM_SIG   = 10;
    localparam int NUM_PINS  = 3;
    localparam int NUM_WORDS = 4;
    localparam int WORD_W    = 16;
    localparam int DIGIT_W   = 4;

    // parameter word indexes
    localparam logic [1:0] IDX_ROUTE_A  = 2'h0;
    localparam logic [1:0] IDX_ROUTE_B  = 2'h1;
    localparam logic [1:0] IDX_ROUTE_C  = 2'h2;
    localparam logic [1:0] IDX_POLARITY = 2'h3;

    // selector codes
    localparam logic [3:0] SEL_NONE  = 4'h0;
    localparam logic [3:0] SEL_PIN0  = 4'h1;
    localparam logic [3:0] SEL_PIN1  = 4'h2;
    localparam logic [3:0] SEL_PIN2  = 4'h3;
    localparam logic [3:0] POL_INVERT = 4'h1;

    // status signal indexes
    localparam int SIG_POSITION_DONE = 0;
    localparam int SIG_SPEED_MATCH   = 1;
    localparam int SIG_ROTATING      = 2;
    localparam int SIG_SERVO_READY   = 3;
    localparam int SIG_TORQUE_LIMIT  = 4;
    localparam int SIG_SPEED_LIMIT   = 5;
    localparam int SIG_BRAKE_RELEASE = 6;
    localparam int SIG_WARNING       = 7;
    localparam int SIG_NEAR_POSITION = 8;
    localparam int SIG_PULSE_ACK     = 9;

    // word and digit holding each signal's selector
    localparam int SIG_WORD  [NUM_SIG] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2};
    localparam int SIG_DIGIT [NUM_SIG] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 2};

    // control modes
    localparam logic [1:0] MODE_SPEED    = 2'h0;
    localparam logic [1:0] MODE_POSITION = 2'h1;
    localparam logic [1:0] MODE_TORQUE   = 2'h2;

    // factory values
    localparam logic [15:0] RST_ROUTE_A  = 16'h0200;
    localparam logic [15:0] RST_ROUTE_B  = 16'h0000;
    localparam logic [15:0] RST_ROUTE_C  = 16'h0000;
    localparam logic [15:0] RST_POLARITY = 16'h0000;

    function automatic logic [3:0] digit_of(input logic [15:0] word, input int k);
        digit_of = word[4*k +: 4];
    endfunction
endpackage : orr_pkg
`default_nettype wire

// ==== rtl/orr_pin_route.sv ====
`timescale 1ns/1ps
`default_nettype none
module orr_pin_route #(
    parameter int NUM_SIG  = 10,
    parameter int NUM_PINS = 3
) (
    input  wire logic [NUM_SIG-1:0]   status,
    input  wire logic [4*NUM_SIG-1:0] sel_flat,
    output logic      [NUM_PINS-1:0]  pin_or
);
    // a 4 bit selector can name at most 15 pins
    if (NUM_PINS > 15 || NUM_SIG < 1) begin : g_bad_size
        $error("orr_pin_route: unsupported size");
    end

    genvar p;
    genvar i;
    generate
        for (p = 0; p < NUM_PINS; p++) begin : g_pin
            logic [NUM_SIG-1:0] hit;
            for (i = 0; i < NUM_SIG; i++) begin : g_sig
                // codes above the pin count never match, so they stay unrouted
                assign hit[i] = status[i] && (sel_flat[4*i +: 4] == 4'(p + 1));
            end
            assign pin_or[p] = |hit;
        end
    endgenerate
endmodule // orr_pin_route
`default_nettype wire

// ==== rtl/orr_router.sv ====
`timescale 1ns/1ps
`default_nettype none
module orr_router (
    input  wire logic                       CLK_SYS,
    input  wire logic                       SYS_RST,
    input  wire logic                       PRM_WR_EN,
    input  wire logic [1:0]                 PRM_IDX,
    input  wire logic [orr_pkg::WORD_W-1:0] PRM_WDATA,
    input  wire logic                       CFG_RELOAD,
    input  wire logic [1:0]                 CTRL_MODE,
    input  wire logic [orr_pkg::NUM_SIG-1:0] STATUS_IN,
    output logic      [orr_pkg::WORD_W-1:0] PRM_RDATA,
    output logic                            CFG_PENDING,
    output logic                            BRAKE_POL_WARN,
    output logic      [orr_pkg::NUM_PINS-1:0] OUT_PIN_DRV,
    output logic      [orr_pkg::NUM_PINS-1:0] OUTPUT_STATE_MONITOR
);
    import orr_pkg::*;

    logic [NUM_WORDS-1:0][WORD_W-1:0] stored_q;
    logic [NUM_WORDS-1:0][WORD_W-1:0] active_q;
    logic                             load_q;
    logic [NUM_PINS-1:0]              pin_q;
    logic [NUM_PINS-1:0]              mon_q;
    logic [WORD_W-1:0]                rdata_q;
    logic                             pending_q;
    logic                             brake_warn_q;

    logic                             apply_cfg;
    logic [NUM_SIG-1:0]               valid_mask;
    logic [NUM_SIG-1:0]               gated_status;
    logic [4*NUM_SIG-1:0]             sel_flat;
    logic [NUM_PINS-1:0]              pin_or;
    logic [NUM_PINS-1:0]              pol_inv;
    logic [NUM_PINS-1:0]              pin_d;
    logic [3:0]                       brake_sel;
    logic                             brake_inv;

    // signals that exist only in some control modes
    function automatic logic [NUM_SIG-1:0] mode_valid(input logic [1:0] mode);
        logic [NUM_SIG-1:0] m;
        m = '1;
        if (mode != MODE_POSITION) begin
            m[SIG_POSITION_DONE] = 1'b0;
            m[SIG_NEAR_POSITION] = 1'b0;
            m[SIG_PULSE_ACK]     = 1'b0;
        end
        if (mode != MODE_SPEED) begin
            m[SIG_SPEED_MATCH] = 1'b0;
        end
        return m;
    endfunction

    // one cycle after reset release plays the part of power-up
    assign apply_cfg    = load_q || CFG_RELOAD;
    assign valid_mask   = mode_valid(CTRL_MODE);
    assign gated_status = STATUS_IN & valid_mask;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SIG; gi++) begin : g_sel
            assign sel_flat[4*gi +: 4] =
                digit_of(active_q[SIG_WORD[gi]], SIG_DIGIT[gi]);
        end
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pol
            assign pol_inv[gi] = digit_of(active_q[IDX_POLARITY], gi) == POL_INVERT;
        end
    endgenerate

    orr_pin_route #(
        .NUM_SIG  (NUM_SIG),
        .NUM_PINS (NUM_PINS)
    ) u_route (
        .status   (gated_status),
        .sel_flat (sel_flat),
        .pin_or   (pin_or)
    );

    assign pin_d     = pin_or ^ pol_inv;
    assign brake_sel = sel_flat[4*SIG_BRAKE_RELEASE +: 4];
    // inverted brake line loses fail-safe on a broken wire
    assign brake_inv = (brake_sel == SEL_PIN0 && pol_inv[0]) ||
                       (brake_sel == SEL_PIN1 && pol_inv[1]) ||
                       (brake_sel == SEL_PIN2 && pol_inv[2]);

    // stored words: what software last wrote
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            stored_q <= {RST_POLARITY, RST_ROUTE_C, RST_ROUTE_B, RST_ROUTE_A};
        end else if (PRM_WR_EN) begin
            stored_q[PRM_IDX] <= PRM_WDATA;
        end
    end

    // active words only move on reset release or CFG_RELOAD
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            active_q <= {RST_POLARITY, RST_ROUTE_C, RST_ROUTE_B, RST_ROUTE_A};
            load_q   <= 1'b1;
        end else begin
            load_q <= 1'b0;
            if (apply_cfg) begin
                active_q <= stored_q;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_q        <= '0;
            mon_q        <= '0;
            rdata_q      <= '0;
            pending_q    <= 1'b0;
            brake_warn_q <= 1'b0;
        end else begin
            pin_q        <= pin_d;
            mon_q        <= pin_d;
            rdata_q      <= stored_q[PRM_IDX];
            pending_q    <= stored_q != active_q;
            brake_warn_q <= brake_inv;
        end
    end

    assign OUT_PIN_DRV          = pin_q;
    assign OUTPUT_STATE_MONITOR = mon_q;
    assign PRM_RDATA            = rdata_q;
    assign CFG_PENDING          = pending_q;
    assign BRAKE_POL_WARN       = brake_warn_q;

    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    logic [3:0] d_a2;
    logic [3:0] d_a3;
    logic [3:0] d_b0;
    logic [3:0] d_b1;
    logic [3:0] d_b2;
    logic [3:0] d_c2;
    logic       any_to_pin0;
    assign d_a2 = digit_of(active_q[IDX_ROUTE_A], 2);
    assign d_a3 = digit_of(active_q[IDX_ROUTE_A], 3);
    assign d_b0 = digit_of(active_q[IDX_ROUTE_B], 0);
    assign d_b1 = digit_of(active_q[IDX_ROUTE_B], 1);
    assign d_b2 = digit_of(active_q[IDX_ROUTE_B], 2);
    assign d_c2 = digit_of(active_q[IDX_ROUTE_C], 2);
    assign any_to_pin0 = |(STATUS_IN & {
        sel_flat[39:36] == SEL_PIN0, sel_flat[35:32] == SEL_PIN0,
        sel_flat[31:28] == SEL_PIN0, sel_flat[27:24] == SEL_PIN0,
        sel_flat[23:20] == SEL_PIN0, sel_flat[19:16] == SEL_PIN0,
        sel_flat[15:12] == SEL_PIN0, sel_flat[11:8]  == SEL_PIN0,
        sel_flat[7:4]   == SEL_PIN0, sel_flat[3:0]   == SEL_PIN0});

    sequence s_write_only;
        PRM_WR_EN && !CFG_RELOAD && !load_q;
    endsequence
    sequence s_reload;
        CFG_RELOAD && !load_q;
    endsequence

    property p_rotating_pin1;
        (d_a2 == SEL_PIN1 && STATUS_IN[SIG_ROTATING] && !pol_inv[1]) |=> OUT_PIN_DRV[1];
    endproperty
    a_rotating_pin1: assert property (p_rotating_pin1) else $error("rotating not on pin1");

    property p_ready_word_a;
        (d_a3 == SEL_PIN2 && STATUS_IN[SIG_SERVO_READY] && !pol_inv[2]) |=> OUT_PIN_DRV[2];
    endproperty
    a_ready_word_a: assert property (p_ready_word_a) else $error("servo ready misrouted");

    property p_brake_word_b;
        (d_b2 == SEL_PIN0 && STATUS_IN[SIG_BRAKE_RELEASE] && pol_inv[0]) |=> !OUT_PIN_DRV[0];
    endproperty
    a_brake_word_b: assert property (p_brake_word_b) else $error("brake misrouted");

    property p_ack_word_c;
        (d_c2 == SEL_PIN2 && STATUS_IN[SIG_PULSE_ACK] && CTRL_MODE == MODE_POSITION
         && !pol_inv[2]) |=> OUT_PIN_DRV[2];
    endproperty
    a_ack_word_c: assert property (p_ack_word_c) else $error("pulse ack misrouted");

    property p_or_shared;
        (d_b0 == SEL_PIN1 && d_b1 == SEL_PIN1 && !pol_inv[1] &&
         (STATUS_IN[SIG_TORQUE_LIMIT] || STATUS_IN[SIG_SPEED_LIMIT])) |=> OUT_PIN_DRV[1];
    endproperty
    a_or_shared: assert property (p_or_shared) else $error("shared pin not ORed");

    property p_mode_gate;
        (CTRL_MODE == MODE_SPEED && sel_flat[3:0] == SEL_PIN0 && !pol_inv[0]
         && STATUS_IN == (NUM_SIG'(1) << SIG_POSITION_DONE)) |=> !OUT_PIN_DRV[0];
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("position done in speed mode");

    property p_invert_idle;
        (pol_inv[0] && !any_to_pin0) |=> OUT_PIN_DRV[0];
    endproperty
    a_invert_idle: assert property (p_invert_idle) else $error("pin0 not inverted");

    property p_hold_mapping;
        s_write_only |=> $stable(active_q);
    endproperty
    a_hold_mapping: assert property (p_hold_mapping) else $error("mapping changed early");

    property p_reload;
        // a write in the reload cycle itself stays pending
        s_reload |=> (active_q == $past(stored_q)) ##1 (!CFG_PENDING || $past(PRM_WR_EN, 2));
    endproperty
    a_reload: assert property (p_reload) else $error("reload did not apply");

    property p_monitor;
        OUTPUT_STATE_MONITOR == OUT_PIN_DRV;
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor differs from pins");
endmodule // orr_router
`default_nettype wire

// ==== verif/orr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module orr_host_model (
    input  wire logic [2:0] pins,
    input  wire logic [2:0] mon,
    output logic      [2:0] seen,
    output logic      [2:0] mon_seen
);
    // host only reads; brake polarity is set by the testbench writes, not here
    assign seen     = pins;
    assign mon_seen = mon;
endmodule // orr_host_model
`default_nettype wire

// ==== verif/orr_router_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module orr_router_tb;
    import orr_pkg::*;
    logic        clk = 0;
    logic        rst = 1;
    logic        wr = 0;
    logic        rl = 0;
    logic [1:0]  idx = 0;
    logic [1:0]  mode = 0;
    logic [15:0] wd = 0;
    logic [9:0]  sin = 0;
    wire  [15:0] rd;
    wire         pend;
    wire         bwarn;
    wire  [2:0]  pins;
    wire  [2:0]  mon;
    wire  [2:0]  seen;
    wire  [2:0]  mseen;
    logic [15:0] act [4];
    logic [15:0] sto [4];
    logic [15:0] w [4];
    logic [2:0]  q [$];
    int          failures = 0;
    int          compares = 0;
    int          cyc = 0;
    int          seed = 41493;

    orr_router dut_u (.CLK_SYS(clk), .SYS_RST(rst), .PRM_WR_EN(wr), .PRM_IDX(idx),
        .PRM_WDATA(wd), .CFG_RELOAD(rl), .CTRL_MODE(mode), .STATUS_IN(sin),
        .PRM_RDATA(rd), .CFG_PENDING(pend), .BRAKE_POL_WARN(bwarn),
        .OUT_PIN_DRV(pins), .OUTPUT_STATE_MONITOR(mon));
    orr_host_model host_u (.pins(pins), .mon(mon), .seen(seen), .mon_seen(mseen));

    initial forever #4 clk = ~clk;

    task tally_and_finish();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ceiling well above the under two thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    task chk_word(string n, logic [15:0] e, logic [15:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask

    task chk_pins(string n, logic [2:0] e, logic [2:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s exp %b got %b", n, e, s);
        end
    endtask

    // brake routed to a pin whose polarity digit is exactly 1
    task chk_brake();
        logic [3:0] sel;
        logic       e;
        sel = act[1][11:8];
        e = sel >= SEL_PIN0 && sel <= SEL_PIN2 && act[3][4*2'(sel - 4'h1) +: 4] == POL_INVERT;
        chk_word("brake_warn", {15'h0, e}, {15'h0, bwarn});
    endtask

    function automatic logic [2:0] exp_pins(logic [9:0] s, logic [1:0] m);
        logic [2:0] p;
        logic [3:0] sel;
        logic       v;
        p = 3'h0;
        for (int i = 0; i < 10; i++) begin
            v = s[i];
            if (i == 0 || i == 8 || i == 9) v = v & (m == MODE_POSITION);
            if (i == 1) v = v & (m == MODE_SPEED);
            sel = act[SIG_WORD[i]][4*SIG_DIGIT[i] +: 4];
            if (sel >= SEL_PIN0 && sel <= SEL_PIN2) p[sel-1] = p[sel-1] | v;
        end
        for (int k = 0; k < 3; k++)
            if (act[3][4*k +: 4] == POL_INVERT) p[k] = ~p[k];
        return p;
    endfunction

    // each note is due at the next rising edge
    always @(posedge clk) begin
        #1;
        if (q.size() > 0) begin
            chk_pins("pins", q[0], seen);
            chk_pins("monitor", q.pop_front(), mseen);
        end
    end

    task drive(logic [9:0] s, logic [1:0] m);
        @(negedge clk);
        sin = s;
        mode = m;
        q.push_back(exp_pins(s, m));
    endtask

    task wr_all();
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            wr = 1;
            idx = 2'(i);
            wd = w[i];
            sto[i] = w[i];
        end
        @(negedge clk);
        wr = 0;
    endtask

    task reload();
        @(negedge clk);
        rl = 1;
        @(negedge clk);
        rl = 0;
        act = sto;
    endtask

    task rd_all();
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            idx = 2'(i);
            @(negedge clk);
            chk_word("rdata", sto[i], rd);
        end
    endtask

    task do_reset();
        rst = 1;
        sto = '{RST_ROUTE_A, RST_ROUTE_B, RST_ROUTE_C, RST_POLARITY};
        act = sto;
        repeat (8) @(negedge clk);
        rst = 0;
        @(negedge clk);
    endtask

    initial begin
        do_reset();
        rd_all();
        drive(10'h004, MODE_SPEED);
        w = '{16'h0000, 16'h0100, 16'h0000, 16'h0000};
        wr_all();
        @(negedge clk);
        chk_word("pending", 16'h0001, {15'h0, pend});
        drive(10'h044, MODE_SPEED);
        reload();
        drive(10'h044, MODE_TORQUE);
        @(negedge clk);
        chk_word("pending", 16'h0000, {15'h0, pend});
        // write in the reload cycle stays pending
        @(negedge clk);
        wr = 1;
        idx = 2'h0;
        wd = 16'h0001;
        rl = 1;
        sto[0] = 16'h0001;
        @(negedge clk);
        wr = 0;
        rl = 0;
        @(negedge clk);
        chk_word("pending", 16'h0001, {15'h0, pend});
        drive(10'h005, MODE_POSITION);
        // directed routes: mode gate, shared pin, word c, then inverted brake
        w = '{16'h0001, 16'h0022, 16'h0300, 16'h0000};
        wr_all();
        reload();
        drive(10'h001, MODE_SPEED);
        drive(10'h030, MODE_TORQUE);
        drive(10'h200, MODE_POSITION);
        w = '{16'h0001, 16'h0100, 16'h0300, 16'h0001};
        wr_all();
        reload();
        repeat (2) @(negedge clk);
        chk_brake();
        drive(10'h040, MODE_TORQUE);
        drive(10'h000, MODE_TORQUE);
        repeat (30) begin
            for (int i = 0; i < 4; i++) w[i] = 16'($random(seed));
            wr_all();
            rd_all();
            reload();
            repeat (2) @(negedge clk);
            chk_brake();
            repeat (40) drive(10'($random(seed)), 2'($random(seed)));
        end
        @(negedge clk);
        do_reset();
        rd_all();
        drive(10'h004, MODE_TORQUE);
        @(negedge clk);
        @(negedge clk);
        tally_and_finish();
    end
endmodule // orr_router_tb
`default_nettype wire
